// file: shared/pat_defs.svh
// Constants for the pipelined converter output timing block
`ifndef PAT_DEFS_SVH
`define PAT_DEFS_SVH

// Word and pipeline geometry
`define PAT_WORD_W      14
`define PAT_AIN_W       16
`define PAT_PTR_W       3
`define PAT_CNT_W       16
`define PAT_LATENCY     3'h5
`define PAT_ALIGN_LAG   3'h3
`define PAT_POS_LIMIT   16'sh1fff
`define PAT_NEG_LIMIT   16'she000
`define PAT_CODE_MAX    14'h3fff
`define PAT_CODE_MIN    14'h0000

// Register byte offsets
`define PAT_REG_CTRL    8'h00
`define PAT_REG_STATUS  8'h04
`define PAT_REG_MASK    8'h08
`define PAT_REG_WORD    8'h0c
`define PAT_REG_COUNT   8'h10

// Field positions and reset values
`define PAT_CTRL_RUN    0
`define PAT_EVT_WORD    0
`define PAT_EVT_OVF     1
`define PAT_ST_PRIMED   2
`define PAT_EVT_W       2
`define PAT_CTRL_RST    1'h1
`define PAT_MASK_RST    2'h0

`endif

// file: shared/pat_pkg.sv
// Types shared by the converter output timing modules
package pat_pkg;
  // Output strobe sequencer, one-hot
  typedef enum logic [2:0] {
    PAT_OUT_IDLE   = 3'h1,
    PAT_OUT_LOAD   = 3'h2,
    PAT_OUT_STROBE = 3'h4
  } pat_out_state_t;

  // Aligned result word: overflow flag above the code
  typedef logic [14:0] pat_result_t;
endpackage

// file: shared/pat_mem_if.sv
// Interface between core and alignment memory
`timescale 1ns/10ps
interface pat_mem_if;
  logic                  wr_en;
  logic [2:0]            wr_addr;
  pat_pkg::pat_result_t  wr_data;
  logic                  rd_en;
  logic [2:0]            rd_addr;
  pat_pkg::pat_result_t  rd_data;

  modport core (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface

// file: verilog/pat_align_mem.sv
// Alignment memory delaying combined results, registered read
`timescale 1ns/10ps
module pat_align_mem
(
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  sys_rst_in,
  // Core side
  pat_mem_if.mem     mem_port
);
  pat_pkg::pat_result_t store [0:7];
  pat_pkg::pat_result_t rd_q;

  // Write port, no reset needed for storage
  always_ff @(posedge clk_in)
  begin
    if (mem_port.wr_en)
    begin
      store[mem_port.wr_addr] <= mem_port.wr_data;
    end
  end

  // Registered read data
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_q <= 15'h0000;
    end
    else if (mem_port.rd_en)
    begin
      rd_q <= store[mem_port.rd_addr];
    end
  end

  assign mem_port.rd_data = rd_q;
endmodule

// file: verilog/pat_core.sv
// Pipelined converter digital core: encode phases, pipeline, output timing
// Operation
// - Encode is high when true input exceeds complement, low otherwise.
// - Track the analog input while encode is low, resume on each fall.
// - Hold the sample on encode rise, feed stage one while high.
// - Residues pass stage one to two on fall, two to three on rise.
// - Adjacent stages work in opposite encode phases.
// - Stage partials are digitally delayed, aligned and combined before output.
// - A sample's result appears five encode cycles after it was taken.
// - Output is a 14-bit word, bit zero least significant.
// - Invert select low flips top bit (two's complement), high leaves it.
// - Outputs driven while drive enable is low, released while high.
// - Data-valid strobe rises with stable data; partner latches on that rise.
// - Overflow flag high when the sample lies outside the representable range.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`include "pat_defs.svh"
module pat_core
(
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  // Converter pins
  input  wire logic                    sample_strobe_pair_p_in,
  input  wire logic                    sample_strobe_pair_n_in,
  input  wire logic [`PAT_AIN_W-1:0]   analog_diff_in,
  input  wire logic                    top_bit_invert_sel_in,
  input  wire logic                    output_drive_en_n_in,
  output logic      [`PAT_WORD_W-1:0]  sample_word_out,
  output logic                         sample_word_oe_out,
  output logic                         data_valid_strobe_out,
  output logic                         range_overflow_flag_out,
  // Wishbone slave
  input  wire logic                    wb_cyc_in,
  input  wire logic                    wb_stb_in,
  input  wire logic                    wb_we_in,
  input  wire logic [7:0]              wb_adr_in,
  input  wire logic [31:0]             wb_dat_in,
  input  wire logic [3:0]              wb_sel_in,
  output logic      [31:0]             wb_dat_out,
  output logic                         wb_ack_out,
  // Interrupt
  output logic                         irq_out
);
  // Clamp a signed sample to the code range, give offset binary and overflow
  function automatic pat_pkg::pat_result_t to_code(input logic signed [15:0] v);
    pat_pkg::pat_result_t r;
    r = {1'b0, ~v[13], v[12:0]};
    if (v > `PAT_POS_LIMIT)
    begin
      r = {1'b1, `PAT_CODE_MAX};
    end
    else if (v < `PAT_NEG_LIMIT)
    begin
      r = {1'b1, `PAT_CODE_MIN};
    end
    return r;
  endfunction

  // Synchroniser stages for pins
  logic                    enc_p_m;
  logic                    enc_p_s;
  logic                    enc_n_m;
  logic                    enc_n_s;
  logic [`PAT_AIN_W-1:0]   ain_m;
  logic [`PAT_AIN_W-1:0]   ain_s;
  logic                    inv_m;
  logic                    inv_s;
  logic                    oe_n_m;
  logic                    oe_n_s;
  // Encode phase tracking
  logic                    enc_level;
  logic                    enc_q;
  logic                    enc_rise;
  logic                    enc_fall;
  // Sample path and stages
  logic [`PAT_AIN_W-1:0]   track;
  logic                    ov1;
  logic [13:0]             s1;
  logic                    ov2;
  logic [3:0]              p1;
  logic [9:0]              s2;
  logic                    ov3;
  logic [3:0]              p1_d;
  logic [3:0]              p2;
  logic [5:0]              s3;
  logic                    ov4;
  logic [3:0]              p1_dd;
  logic [3:0]              p2_d;
  logic [2:0]              p3;
  logic [2:0]              s4;
  // Alignment and output
  logic [`PAT_PTR_W-1:0]   wr_ptr;
  logic [2:0]              rise_cnt;
  logic                    primed;
  pat_pkg::pat_out_state_t out_state;
  pat_pkg::pat_out_state_t next_out_state;
  // Registers
  logic                    ctrl_run;
  logic [`PAT_EVT_W-1:0]   status;
  logic [`PAT_EVT_W-1:0]   mask;
  logic [`PAT_EVT_W-1:0]   evt;
  logic [`PAT_CNT_W-1:0]   sample_cnt;
  logic                    wb_req;
  logic                    wb_wr;

  pat_mem_if mem_bus ();

  pat_align_mem u_align_mem
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .mem_port   (mem_bus)
  );

  // Two flops on every pin before use
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      enc_p_m <= 1'b0;
      enc_p_s <= 1'b0;
      enc_n_m <= 1'b0;
      enc_n_s <= 1'b0;
      ain_m   <= 16'h0000;
      ain_s   <= 16'h0000;
      inv_m   <= 1'b0;
      inv_s   <= 1'b0;
      oe_n_m  <= 1'b1;
      oe_n_s  <= 1'b1;
    end
    else
    begin
      enc_p_m <= sample_strobe_pair_p_in;
      enc_p_s <= enc_p_m;
      enc_n_m <= sample_strobe_pair_n_in;
      enc_n_s <= enc_n_m;
      ain_m   <= analog_diff_in;
      ain_s   <= ain_m;
      inv_m   <= top_bit_invert_sel_in;
      inv_s   <= inv_m;
      oe_n_m  <= output_drive_en_n_in;
      oe_n_s  <= oe_n_m;
    end
  end

  assign enc_level = enc_p_s > enc_n_s;
  assign enc_rise  = ctrl_run & enc_level & ~enc_q;
  assign enc_fall  = ctrl_run & ~enc_level & enc_q;

  // Previous phase for edge detection
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      enc_q <= 1'b0;
    end
    else
    begin
      enc_q <= enc_level;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      track <= 16'h0000;
    end
    else if (!enc_level)
    begin
      track <= ain_s;
    end
  end

  // hold on rise, buffered into stage one
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      {ov1, s1} <= 15'h0000;
    end
    else if (enc_rise)
    begin
      {ov1, s1} <= to_code($signed(track));
    end
  end

  // stage one residue to stage two on fall
  // even stages acquire while odd ones output
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ov2   <= 1'b0;
      p1    <= 4'h0;
      s2    <= 10'h000;
      ov4   <= 1'b0;
      p1_dd <= 4'h0;
      p2_d  <= 4'h0;
      p3    <= 3'h0;
      s4    <= 3'h0;
    end
    else if (enc_fall)
    begin
      ov2   <= ov1;
      p1    <= s1[13:10];
      s2    <= s1[9:0];
      ov4   <= ov3;
      p1_dd <= p1_d;
      p2_d  <= p2;
      p3    <= s3[5:3];
      s4    <= s3[2:0];
    end
  end

  // stage two residue to stage three on rise
  // earlier partials delayed to line up
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ov3  <= 1'b0;
      p1_d <= 4'h0;
      p2   <= 4'h0;
      s3   <= 6'h00;
    end
    else if (enc_rise)
    begin
      ov3  <= ov2;
      p1_d <= p1;
      p2   <= s2[9:6];
      s3   <= s2[5:0];
    end
  end

  // combined word written to alignment memory
  // read back three encode cycles later, five after the sample
  assign mem_bus.wr_en   = enc_rise;
  assign mem_bus.wr_addr = wr_ptr;
  assign mem_bus.wr_data = {ov4, p1_dd, p2_d, p3, s4};
  assign mem_bus.rd_en   = enc_rise;
  assign mem_bus.rd_addr = wr_ptr - `PAT_ALIGN_LAG;

  // Write pointer advances once per sample
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr <= 3'h0;
    end
    else if (enc_rise)
    begin
      wr_ptr <= wr_ptr + 3'h1;
    end
  end

  // count first encode cycles; stopping the run restarts priming
  // Primed by the rise after the fifth, so the first strobed word is real
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rise_cnt <= 3'h0;
      primed   <= 1'b0;
    end
    else if (!ctrl_run)
    begin
      rise_cnt <= 3'h0;
      primed   <= 1'b0;
    end
    else if (enc_rise && rise_cnt == `PAT_LATENCY)
    begin
      primed <= 1'b1;
    end
    else if (enc_rise)
    begin
      rise_cnt <= rise_cnt + 3'h1;
    end
  end

  // Strobe sequencer: load data and raise strobe on the same edge
  always_comb
  begin
    next_out_state = out_state;
    case (out_state)
      pat_pkg::PAT_OUT_IDLE:
        if (enc_rise)
        begin
          next_out_state = pat_pkg::PAT_OUT_LOAD;
        end
      pat_pkg::PAT_OUT_LOAD:
        next_out_state = pat_pkg::PAT_OUT_STROBE;
      pat_pkg::PAT_OUT_STROBE:
        if (enc_rise)
        begin
          next_out_state = pat_pkg::PAT_OUT_LOAD;
        end
        else if (enc_fall)
        begin
          next_out_state = pat_pkg::PAT_OUT_IDLE;
        end
      default:
        next_out_state = pat_pkg::PAT_OUT_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      out_state <= pat_pkg::PAT_OUT_IDLE;
    end
    else
    begin
      out_state <= next_out_state;
    end
  end

  // output word, top bit flipped when select is low
  // overflow flag travels with its word
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sample_word_out         <= 14'h0000;
      range_overflow_flag_out <= 1'b0;
    end
    else if (out_state == pat_pkg::PAT_OUT_LOAD)
    begin
      sample_word_out         <= {mem_bus.rd_data[13] ^ ~inv_s, mem_bus.rd_data[12:0]};
      range_overflow_flag_out <= mem_bus.rd_data[14];
    end
  end

  // strobe rises on the same edge that loads the data, falls on encode fall
  // suppressed until the pipeline holds real samples
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      data_valid_strobe_out <= 1'b0;
    end
    else
    begin
      data_valid_strobe_out <= (next_out_state == pat_pkg::PAT_OUT_STROBE) && primed;
    end
  end

  // drive only while enable pin is low
  assign sample_word_oe_out = ~oe_n_s;

  // Events for the sticky status
  assign evt[`PAT_EVT_WORD] = (out_state == pat_pkg::PAT_OUT_LOAD) && primed;
  assign evt[`PAT_EVT_OVF]  = (out_state == pat_pkg::PAT_OUT_LOAD) && primed
                              && mem_bus.rd_data[14];

  // Bus request decode
  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wb_wr  = wb_req & wb_we_in & wb_sel_in[0];

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wb_ack_out <= 1'b0;
    end
    else
    begin
      wb_ack_out <= wb_req;
    end
  end

  // Control and mask registers
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_run <= `PAT_CTRL_RST;
      mask     <= `PAT_MASK_RST;
    end
    else if (wb_wr && wb_adr_in == `PAT_REG_CTRL)
    begin
      ctrl_run <= wb_dat_in[`PAT_CTRL_RUN];
    end
    else if (wb_wr && wb_adr_in == `PAT_REG_MASK)
    begin
      mask <= wb_dat_in[`PAT_EVT_W-1:0];
    end
  end

  // Sticky status, write one clears; a new event beats the clear
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      status <= 2'h0;
    end
    else if (wb_wr && wb_adr_in == `PAT_REG_STATUS)
    begin
      status <= (status & ~wb_dat_in[`PAT_EVT_W-1:0]) | evt;
    end
    else
    begin
      status <= status | evt;
    end
  end

  // Samples taken, wraps
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sample_cnt <= 16'h0000;
    end
    else if (enc_rise)
    begin
      sample_cnt <= sample_cnt + 16'h0001;
    end
  end

  // Read data registered with the ack; unmapped reads zero
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wb_dat_out <= 32'h0000_0000;
    end
    else if (wb_req)
    begin
      case (wb_adr_in)
        `PAT_REG_CTRL:   wb_dat_out <= {31'h0, ctrl_run};
        `PAT_REG_STATUS: wb_dat_out <= {29'h0, primed, status};
        `PAT_REG_MASK:   wb_dat_out <= {30'h0, mask};
        `PAT_REG_WORD:   wb_dat_out <= {17'h0, range_overflow_flag_out, sample_word_out};
        `PAT_REG_COUNT:  wb_dat_out <= {16'h0, sample_cnt};
        default:         wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  // Level interrupt from unmasked sticky bits
  assign irq_out = |(status & mask);
endmodule

// file: test/pat_core_assertions.sv
// Concurrent checks on the converter output timing block ports
`timescale 1ns/10ps
`include "pat_defs.svh"
module pat_core_assertions
(
  // Clock and reset
  input wire logic                   clk_in,
  input wire logic                   sys_rst_in,
  // Converter pins
  input wire logic                   sample_strobe_pair_p_in,
  input wire logic                   sample_strobe_pair_n_in,
  input wire logic                   output_drive_en_n_in,
  input wire logic [`PAT_WORD_W-1:0] sample_word_out,
  input wire logic                   sample_word_oe_out,
  input wire logic                   data_valid_strobe_out,
  input wire logic                   range_overflow_flag_out,
  // Bus and interrupt
  input wire logic                   wb_cyc_in,
  input wire logic                   wb_stb_in,
  input wire logic                   wb_ack_out,
  input wire logic                   irq_out
);
  // Encode level as the pair compares; equal inputs read as low
  wire enc_w = sample_strobe_pair_p_in & ~sample_strobe_pair_n_in;

  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Bus answer timing
  ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  ack_prompt_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered on the next edge");
  ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in) && $past(wb_stb_in))
    else $error("ack without a request");

  // Output drive follows the enable after its two sync stages
  oe_on_a: assert property ($fell(output_drive_en_n_in) |-> ##[1:3] sample_word_oe_out)
    else $error("outputs not driven after enable");
  oe_off_a: assert property ($rose(output_drive_en_n_in) |-> ##[1:3] !sample_word_oe_out)
    else $error("outputs not released after disable");

  // Strobe framing against encode; sync delay bounds the windows
  strobe_drop_a: assert property ($fell(enc_w) |-> ##[1:5] !data_valid_strobe_out)
    else $error("strobe still high after encode fall");
  strobe_cause_a: assert property ($rose(data_valid_strobe_out) |->
    $past(enc_w, 4) || $past(enc_w, 5) || $past(enc_w, 6) || $past(enc_w, 7))
    else $error("strobe rose without an encode high");
  word_hold_a: assert property (data_valid_strobe_out &&
    $past(data_valid_strobe_out) |-> $stable(sample_word_out) && $stable(range_overflow_flag_out))
    else $error("word moved while strobe high");
  word_change_a: assert property ($changed(sample_word_out) ||
    $changed(range_overflow_flag_out) |-> !$past(data_valid_strobe_out))
    else $error("word or flag moved outside a load");

  // Main scenarios reached
  cover property ($rose(data_valid_strobe_out));
  cover property ($rose(irq_out));
  cover property ($fell(sample_word_oe_out));
  cover property (range_overflow_flag_out && data_valid_strobe_out);
endmodule

bind pat_core pat_core_assertions chk (.clk_in, .sys_rst_in, .sample_strobe_pair_p_in,
  .sample_strobe_pair_n_in, .output_drive_en_n_in, .sample_word_out, .sample_word_oe_out,
  .data_valid_strobe_out, .range_overflow_flag_out, .wb_cyc_in, .wb_stb_in, .wb_ack_out,
  .irq_out);

// file: test/pat_capture_model.sv
// Capturing logic model that latches words on the data-valid rise
`timescale 1ns/10ps
module pat_capture_model
(
  // Clock
  input wire logic        clk_in,
  // Converter outputs
  input wire logic [13:0] word_in,
  input wire logic        oe_in,
  input wire logic        strobe_in,
  input wire logic        ovf_in
);
  logic [14:0] q[$];
  logic        prev = 1'b0;
  // Released pins show the inverse, so a capture then is visibly wrong
  wire  [13:0] pins = oe_in ? word_in : ~word_in;

  always @(posedge clk_in)
  begin
    if (strobe_in === 1'b1 && prev === 1'b0)
      q.push_back({ovf_in, pins});
    prev <= strobe_in;
  end
endmodule

// file: test/tb.sv
// Self-checking bench for the converter output timing block
`timescale 1ns/10ps
module tb;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        enc_p = 1'b0;
  logic        enc_n = 1'b1;
  logic [15:0] ain = 16'h0000;
  logic        inv_sel = 1'b0;
  logic        oen = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic [13:0] word;
  logic        oe, dvs, ovf, ack, irq;
  int          n_fail = 0;
  int          comparisons = 0;
  int          ticks = 0;
  logic [15:0] v[12] = '{16'h0000, 16'h0001, 16'h1fff, 16'he000, 16'h2328, 16'hdcd8,
                         16'hffff, 16'h1234, 16'h0abc, 16'hf00f, 16'h2000, 16'hdfff};

  pat_core uut (.clk_in, .sys_rst_in, .sample_strobe_pair_p_in(enc_p),
    .sample_strobe_pair_n_in(enc_n), .analog_diff_in(ain), .top_bit_invert_sel_in(inv_sel),
    .output_drive_en_n_in(oen), .sample_word_out(word), .sample_word_oe_out(oe),
    .data_valid_strobe_out(dvs), .range_overflow_flag_out(ovf), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel),
    .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq));
  pat_capture_model cap (.clk_in, .word_in(word), .oe_in(oe), .strobe_in(dvs),
    .ovf_in(ovf));

  // Clock and hang guard
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    ticks <= ticks + 1;
    if (ticks == 20000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; waits for ack without assuming a latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (t = 0; t < 40; t++)
    begin
      @(posedge clk_in);
      if (ack === 1'b1)
        break;
    end
    rd = rdat;
    chk({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_in);
  endtask

  // Encode parked low in reset, else a high pin reads as a false rise
  task automatic do_reset();
    sys_rst_in <= 1'b1;
    enc_p <= 1'b0;
    enc_n <= 1'b1;
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    cap.q.delete();
  endtask

  // One encode period; the low half uses the given pair levels
  task automatic sample_strobe_pair(input logic [15:0] a, input logic [1:0] lo);
    ain <= a;
    enc_p <= lo[1];
    enc_n <= lo[0];
    repeat (8) @(posedge clk_in);
    enc_p <= 1'b1;
    enc_n <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask

  // Clamped code with flag, top bit flipped for offset binary
  function automatic logic [31:0] expw(input logic [15:0] a, input logic s);
    logic signed [15:0] x;
    logic o;
    x = a;
    o = 1'b0;
    if (x > 16'sh1fff)
    begin
      x = 16'sh1fff;
      o = 1'b1;
    end
    else if (x < 16'she000)
    begin
      x = 16'she000;
      o = 1'b1;
    end
    return {17'h0, o, x[13:0] ^ {s, 13'h0}};
  endfunction

  logic [7:0] adr_l[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

  // Reset values, unmapped and read-only places, ignored byte lane
  task automatic regs_check();
    wb(1'b1, 8'h14, 32'h3);
    wb(1'b1, 8'h0c, 32'h7fff);
    wb(1'b1, 8'h08, 32'h0000_0300);
    sel <= 4'he;
    wb(1'b1, 8'h00, 32'h0);
    sel <= 4'hf;
    foreach (adr_l[i])
    begin
      wb(1'b0, adr_l[i], 32'h0);
      chk(rd, {31'h0, i == 0});
    end
  endtask

  // Stream with latency, priming, coding, overflow and interrupt
  task automatic stream(input logic s);
    int i;
    do_reset();
    inv_sel <= s;
    regs_check();
    for (i = 0; i < 17; i++)
      sample_strobe_pair(i < 12 ? v[i] : 16'h0000, i % 3 == 0 ? 2'b01 : (i % 3 == 1 ? 2'b11 : 2'b00));
    chk(32'(cap.q.size()), 32'd12);
    for (i = 0; i < 12 && i < cap.q.size(); i++)
      chk({17'h0, cap.q[i]}, expw(v[i], s));
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, expw(v[11], s));
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'd17);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h08, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h04, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h4);
  endtask

  // Run off ignores encode, re-enable primes again
  task automatic run_gate();
    int i;
    cap.q.delete();
    wb(1'b1, 8'h00, 32'h0);
    for (i = 0; i < 3; i++)
      sample_strobe_pair(16'h0100, 2'b01);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'd17);
    wb(1'b1, 8'h00, 32'h1);
    for (i = 0; i < 6; i++)
      sample_strobe_pair(16'h0555 + 16'(i), 2'b01);
    chk(32'(cap.q.size()), 32'd1);
    chk({17'h0, cap.q[0]}, expw(16'h0555, 1'b1));
  endtask

  // Output drive on and off
  task automatic drive_check();
    oen <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk({31'h0, oe}, 32'h0);
    oen <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk({31'h0, oe}, 32'h1);
  endtask

  initial
  begin
    stream(1'b0);
    stream(1'b1);
    run_gate();
    drive_check();
    close_out();
  end
endmodule
